//--- verilog/tdc_pkg.sv
package tdc_pkg;

    // Data word width of the operand, result and clock words.
    localparam int TDC_WORD_W = 16;
    // Width of the APB address seen by the block.
    localparam int TDC_ADDR_W = 8;

    // Register byte offsets, one aligned 32-bit word each.
    localparam logic [7:0] TDC_ADDR_CTRL = 8'h00;
    localparam logic [7:0] TDC_ADDR_OPND_FIRST = 8'h04;
    localparam logic [7:0] TDC_ADDR_OPND_LAST = 8'h24;
    localparam logic [7:0] TDC_ADDR_RES_HOUR = 8'h28;
    localparam logic [7:0] TDC_ADDR_RES_MIN = 8'h2C;
    localparam logic [7:0] TDC_ADDR_RES_SEC = 8'h30;
    localparam logic [7:0] TDC_ADDR_CMP = 8'h34;
    localparam logic [7:0] TDC_ADDR_FLAGS = 8'h38;
    localparam logic [7:0] TDC_ADDR_ERRCODE = 8'h3C;
    localparam logic [7:0] TDC_ADDR_CLK_HOUR = 8'h40;
    localparam logic [7:0] TDC_ADDR_CLK_MIN = 8'h44;
    localparam logic [7:0] TDC_ADDR_CLK_SEC = 8'h48;

    // Operand word count: three triples of hour, minute, second.
    localparam int TDC_OPND_WORDS = 9;
    // Word index of each triple base within the operand array.
    localparam int TDC_IDX_A = 0;
    localparam int TDC_IDX_B = 3;
    localparam int TDC_IDX_C = 6;

    // Control register field positions.
    localparam int TDC_CTRL_EN_BIT = 0;
    localparam int TDC_CTRL_OP_LSB = 1;
    localparam int TDC_CTRL_CLK_BIT = 3;
    localparam int TDC_CTRL_W = 4;

    // Flag register field positions.
    localparam int TDC_FLAG_CARRY = 0;
    localparam int TDC_FLAG_ZERO = 1;
    localparam int TDC_FLAG_BORROW = 2;
    localparam int TDC_FLAG_ERR_A = 3;
    localparam int TDC_FLAG_ERR_B = 4;
    localparam int TDC_FLAG_W = 5;

    // Time limits and wrap values.
    localparam logic [15:0] TDC_HOUR_MAX = 16'h0017;
    localparam logic [15:0] TDC_MINSEC_MAX = 16'h003B;
    localparam logic [15:0] TDC_HOURS_PER_DAY = 16'h0018;
    localparam logic [15:0] TDC_UNITS_PER_NEXT = 16'h003C;

    // Operation error code stored on an operand out of range.
    localparam logic [15:0] TDC_ERR_CODE_RANGE = 16'h0E1A;

    // Reset values.
    localparam logic [15:0] TDC_WORD_RST = 16'h0000;
    localparam logic [3:0] TDC_CTRL_RST = 4'h0;
    localparam logic [4:0] TDC_FLAG_RST = 5'h00;
    localparam logic [2:0] TDC_CMP_RST = 3'h0;

    // Operation selected by the control register.
    typedef enum logic [1:0] {
        TDC_OP_POINT,
        TDC_OP_ZONE,
        TDC_OP_ADD,
        TDC_OP_SUB
    } tdc_op_e;

endpackage : tdc_pkg

//--- verilog/tdc_time_unit.sv
// What this block does
// - Point compare checks reference time against current time into three result bits.
// - Current time is three words: hour 0-23, minute and second 0-59.
// - Any operand the operation reads out of range: skip, set both error flags, code 0E1A.
// - When enable drops, execution stops and result bits hold their states.
// - Zone compare: bit0 below both limits, bit2 above both, else bit1.
// - Zone lower, upper and current operands are hour, minute, second triples.
// - Addition writes hour, minute, second sum of two triples to result.
// - Sum of 24 hours or more raises carry and keeps only the excess.
// - Sum of exactly zero time raises the zero flag.
// - Subtraction writes minuend minus subtrahend triple to result words.
// - Negative difference raises borrow and leaves the wrapped time.
// - Difference of exactly zero time raises the zero flag.
// - Clock words hold second 0-59, minute 0-59, hour 0-23.
`timescale 1ns/1ps
module tdc_time_unit
    import tdc_pkg::*;
#(
    parameter int WORD_W = TDC_WORD_W
) (
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    // APB slave.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [TDC_ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Result bits and flags for the surrounding controller.
    output logic [2:0] CMP_BITS,
    output logic CARRY_FLAG,
    output logic ZERO_FLAG,
    output logic BORROW_FLAG,
    output logic OP_ERROR
);

    // Register state.
    logic pready_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;

    // Control and operand words written by software.
    logic [TDC_CTRL_W-1:0] ctrl_reg;
    logic [WORD_W-1:0] opnd_reg [0:TDC_OPND_WORDS-1];

    // Results of the last successful run, plus the flags and error code.
    logic [WORD_W-1:0] res_hour_reg;
    logic [WORD_W-1:0] res_min_reg;
    logic [WORD_W-1:0] res_sec_reg;
    logic [2:0] cmp_reg;
    logic [TDC_FLAG_W-1:0] flag_reg;
    logic [TDC_FLAG_W-1:0] flag_next;
    logic [WORD_W-1:0] errcode_reg;

    // Clock words, always kept in range.
    logic [WORD_W-1:0] clk_hour_reg;
    logic [WORD_W-1:0] clk_min_reg;
    logic [WORD_W-1:0] clk_sec_reg;

    // Bus decode: a transfer completes on the edge where pready is seen high.
    wire bus_done = PSEL && PENABLE && pready_reg;
    wire wr_en = bus_done && PWRITE;
    wire [WORD_W-1:0] wr_word = PWDATA[WORD_W-1:0];
    wire hit_ctrl = (PADDR == TDC_ADDR_CTRL);
    // Operand words span a range; a misaligned address misses it.
    wire hit_opnd = (PADDR >= TDC_ADDR_OPND_FIRST) && (PADDR <= TDC_ADDR_OPND_LAST)
        && (PADDR[1:0] == 2'b00);
    wire [TDC_ADDR_W-1:0] opnd_off = PADDR - TDC_ADDR_OPND_FIRST;
    wire [3:0] opnd_idx = opnd_off[5:2];

    // Every other word decodes on its exact address.
    wire hit_res_h = (PADDR == TDC_ADDR_RES_HOUR);
    wire hit_res_m = (PADDR == TDC_ADDR_RES_MIN);
    wire hit_res_s = (PADDR == TDC_ADDR_RES_SEC);
    wire hit_cmp = (PADDR == TDC_ADDR_CMP);
    wire hit_flags = (PADDR == TDC_ADDR_FLAGS);
    wire hit_err = (PADDR == TDC_ADDR_ERRCODE);
    wire hit_clk_h = (PADDR == TDC_ADDR_CLK_HOUR);
    wire hit_clk_m = (PADDR == TDC_ADDR_CLK_MIN);
    wire hit_clk_s = (PADDR == TDC_ADDR_CLK_SEC);
    // An address outside the map answers with the slave error.
    wire hit_any = hit_ctrl || hit_opnd || hit_res_h || hit_res_m || hit_res_s || hit_cmp
        || hit_flags || hit_err || hit_clk_h || hit_clk_m || hit_clk_s;

    // Control fields.
    // Enable is the run condition; the rest choose what runs.
    wire exec_en = ctrl_reg[TDC_CTRL_EN_BIT];
    wire use_clock = ctrl_reg[TDC_CTRL_CLK_BIT];
    wire tdc_op_e op_sel = tdc_op_e'(ctrl_reg[TDC_CTRL_OP_LSB+:2]);

    // Operand triples; the current time may come straight from the clock words.
    wire [WORD_W-1:0] a_h = opnd_reg[TDC_IDX_A];
    wire [WORD_W-1:0] a_m = opnd_reg[TDC_IDX_A+1];
    wire [WORD_W-1:0] a_s = opnd_reg[TDC_IDX_A+2];
    wire [WORD_W-1:0] b_h = opnd_reg[TDC_IDX_B];
    wire [WORD_W-1:0] b_m = opnd_reg[TDC_IDX_B+1];
    wire [WORD_W-1:0] b_s = opnd_reg[TDC_IDX_B+2];

    // Taking C from the clock words saves software a copy
    // of the time before each compare.
    wire [WORD_W-1:0] c_h = use_clock ? clk_hour_reg : opnd_reg[TDC_IDX_C];
    wire [WORD_W-1:0] c_m = use_clock ? clk_min_reg : opnd_reg[TDC_IDX_C+1];
    wire [WORD_W-1:0] c_s = use_clock ? clk_sec_reg : opnd_reg[TDC_IDX_C+2];

    // Range checks of each triple.
    // A bad field must never produce a result that looks valid.
    wire a_ok = (a_h <= TDC_HOUR_MAX) && (a_m <= TDC_MINSEC_MAX) && (a_s <= TDC_MINSEC_MAX);
    wire b_ok = (b_h <= TDC_HOUR_MAX) && (b_m <= TDC_MINSEC_MAX) && (b_s <= TDC_MINSEC_MAX);
    wire c_ok = (c_h <= TDC_HOUR_MAX) && (c_m <= TDC_MINSEC_MAX)
        && (c_s <= TDC_MINSEC_MAX);

    // Each operation checks only the triples it reads.
    wire opnd_ok = (op_sel == TDC_OP_POINT) ? (a_ok && c_ok) :
                   (op_sel == TDC_OP_ZONE) ? (a_ok && b_ok && c_ok) :
                   (a_ok && b_ok);
    // Arithmetic ignores C, so a stale current time cannot block it.

    // Times ordered as one key since every field is in range when used.
    // Hour is most significant, so an unsigned compare orders times.
    wire [3*WORD_W-1:0] key_a = {a_h, a_m, a_s};
    wire [3*WORD_W-1:0] key_b = {b_h, b_m, b_s};
    wire [3*WORD_W-1:0] key_c = {c_h, c_m, c_s};

    // Point compare: reference greater, equal, less than current.
    // The three relations exclude each other, so one bit is on.
    wire [2:0] point_bits = {key_a < key_c, key_a == key_c, key_a > key_c};

    // Zone compare against the lower and upper limit; a reversed zone still yields one bit.
    wire zone_below = (key_c < key_a) && (key_c < key_b);
    wire zone_above = (key_c > key_a) && (key_c > key_b);
    wire [2:0] zone_bits = {zone_above, !zone_below && !zone_above, zone_below};
    // A reversed zone is a software fault and raises no error.

    // Addition field by field with carries into the next larger unit.
    wire [WORD_W-1:0] add_s_raw = WORD_W'(a_s + b_s);
    wire add_s_c = (add_s_raw >= TDC_UNITS_PER_NEXT);
    wire [WORD_W-1:0] add_s = add_s_c ? WORD_W'(add_s_raw - TDC_UNITS_PER_NEXT) : add_s_raw;
    wire [WORD_W-1:0] add_m_raw = WORD_W'(a_m + b_m + {{(WORD_W-1){1'b0}}, add_s_c});
    wire add_m_c = (add_m_raw >= TDC_UNITS_PER_NEXT);
    wire [WORD_W-1:0] add_m = add_m_c ? WORD_W'(add_m_raw - TDC_UNITS_PER_NEXT) : add_m_raw;
    wire [WORD_W-1:0] add_h_raw = WORD_W'(a_h + b_h + {{(WORD_W-1){1'b0}}, add_m_c});
    wire add_carry = (add_h_raw >= TDC_HOURS_PER_DAY);
    wire [WORD_W-1:0] add_h = add_carry ? WORD_W'(add_h_raw - TDC_HOURS_PER_DAY) : add_h_raw;
    wire add_zero = !add_carry && (add_h == '0) && (add_m == '0) && (add_s == '0);
    // An exact 24:00:00 sum carries and leaves zero time;
    // the zero flag stays off, as the sum is a full day.

    // Subtraction field by field with borrows out of the next larger unit.
    wire sub_s_b = (a_s < b_s);
    wire [WORD_W-1:0] sub_s_raw = WORD_W'(a_s - b_s);
    wire [WORD_W-1:0] sub_s = sub_s_b ? WORD_W'(sub_s_raw + TDC_UNITS_PER_NEXT) : sub_s_raw;
    wire [WORD_W-1:0] sub_m_take = WORD_W'(b_m + {{(WORD_W-1){1'b0}}, sub_s_b});
    wire sub_m_b = (a_m < sub_m_take);
    wire [WORD_W-1:0] sub_m_raw = WORD_W'(a_m - sub_m_take);
    wire [WORD_W-1:0] sub_m = sub_m_b ? WORD_W'(sub_m_raw + TDC_UNITS_PER_NEXT) : sub_m_raw;
    wire [WORD_W-1:0] sub_h_take = WORD_W'(b_h + {{(WORD_W-1){1'b0}}, sub_m_b});
    wire sub_borrow = (a_h < sub_h_take);
    wire [WORD_W-1:0] sub_h_raw = WORD_W'(a_h - sub_h_take);
    // A negative difference counts back from the end of a day.
    wire [WORD_W-1:0] sub_h = sub_borrow ? WORD_W'(sub_h_raw + TDC_HOURS_PER_DAY) : sub_h_raw;
    wire sub_zero = !sub_borrow && (sub_h == '0) && (sub_m == '0) && (sub_s == '0);
    // Borrow and zero never rise together.

    // Execution strobes; nothing runs while the enable bit is off.
    // The unit reruns each cycle enable stays on; unchanged operands
    // give the same values, and dropping enable freezes every result.
    wire is_arith = (op_sel == TDC_OP_ADD) || (op_sel == TDC_OP_SUB);
    wire run_ok = exec_en && opnd_ok;
    wire run_err = exec_en && !opnd_ok;

    // Clock word writes outside their range are refused and reported.
    // The old time stays, so a compare fed from the clock stays sane.
    wire clk_wr_bad = wr_en && ((hit_clk_h && (wr_word > TDC_HOUR_MAX))
        || ((hit_clk_m || hit_clk_s) && (wr_word > TDC_MINSEC_MAX)));
    wire err_event = run_err || clk_wr_bad;

    // Read data selection; reserved bits read as zero.
    // Unmapped addresses read zero.
    wire [WORD_W-1:0] rd_opnd = opnd_reg[opnd_idx];
    wire [31:0] rd_data =
        hit_ctrl ? {{(32-TDC_CTRL_W){1'b0}}, ctrl_reg} :
        hit_opnd ? {{(32-WORD_W){1'b0}}, rd_opnd} :
        hit_res_h ? {{(32-WORD_W){1'b0}}, res_hour_reg} :
        hit_res_m ? {{(32-WORD_W){1'b0}}, res_min_reg} :
        hit_res_s ? {{(32-WORD_W){1'b0}}, res_sec_reg} :
        hit_cmp ? {29'h0000000, cmp_reg} :
        hit_flags ? {{(32-TDC_FLAG_W){1'b0}}, flag_reg} :
        hit_err ? {{(32-WORD_W){1'b0}}, errcode_reg} :
        hit_clk_h ? {{(32-WORD_W){1'b0}}, clk_hour_reg} :
        hit_clk_m ? {{(32-WORD_W){1'b0}}, clk_min_reg} :
        hit_clk_s ? {{(32-WORD_W){1'b0}}, clk_sec_reg} :
        32'h00000000;

    // APB handshake: one wait cycle, then data, error and ready stand for one cycle.
    // Ready never stands two cycles running, which ends each access.
    // A new setup right after ready is accepted.
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= PSEL && PENABLE && !pready_reg;
            prdata_reg <= (PSEL && PENABLE && !pready_reg && !PWRITE) ? rd_data : 32'h00000000;
            pslverr_reg <= PSEL && PENABLE && !pready_reg && !hit_any;
        end
    end

    // Control register written by software.
    // A new operation acts from the cycle after the write.
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            ctrl_reg <= TDC_CTRL_RST;
        end else if (wr_en && hit_ctrl) begin
            ctrl_reg <= PWDATA[TDC_CTRL_W-1:0];
        end
    end

    // Operand words, one writable word each.
    // Each word's enable is an index match gated by the operand range hit.
    genvar gi;
    generate
        for (gi = 0; gi < TDC_OPND_WORDS; gi++) begin : g_opnd
            always_ff @(posedge REF_CLK) begin
                if (SYS_RST) begin
                    opnd_reg[gi] <= TDC_WORD_RST;
                end else if (wr_en && hit_opnd && (opnd_idx == 4'(gi))) begin
                    opnd_reg[gi] <= wr_word;
                end
            end
        end
    endgenerate

    // Clock words: only in-range values are accepted.
    // A refused write also raises the operation error.
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            clk_hour_reg <= TDC_WORD_RST;
            clk_min_reg <= TDC_WORD_RST;
            clk_sec_reg <= TDC_WORD_RST;
        end else if (wr_en && !clk_wr_bad) begin
            if (hit_clk_h) begin
                clk_hour_reg <= wr_word;
            end
            if (hit_clk_m) begin
                clk_min_reg <= wr_word;
            end
            if (hit_clk_s) begin
                clk_sec_reg <= wr_word;
            end
        end
    end

    // Compare result bits change only on a successful compare run.
    // Errors and arithmetic leave them untouched.
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            cmp_reg <= TDC_CMP_RST;
        end else if (run_ok && (op_sel == TDC_OP_POINT)) begin
            cmp_reg <= point_bits;
        end else if (run_ok && (op_sel == TDC_OP_ZONE)) begin
            cmp_reg <= zone_bits;
        end
    end

    // Result words from a successful addition or subtraction.
    // A run that fails its range check keeps the old result.
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            res_hour_reg <= TDC_WORD_RST;
            res_min_reg <= TDC_WORD_RST;
            res_sec_reg <= TDC_WORD_RST;
        end else if (run_ok && (op_sel == TDC_OP_ADD)) begin
            res_hour_reg <= add_h;
            res_min_reg <= add_m;
            res_sec_reg <= add_s;
        end else if (run_ok && (op_sel == TDC_OP_SUB)) begin
            res_hour_reg <= sub_h;
            res_min_reg <= sub_m;
            res_sec_reg <= sub_s;
        end
    end

    // Flag update: write-one clears, and a hardware event in the same cycle wins.
    // Each successful add or subtract rewrites carry, zero and borrow,
    // so no stale carry, zero or borrow survives the next successful add or subtract.
    always_comb begin
        flag_next = flag_reg;
        if (wr_en && hit_flags) begin
            flag_next = flag_reg & ~PWDATA[TDC_FLAG_W-1:0];
        end
        if (run_ok && is_arith) begin
            flag_next[TDC_FLAG_CARRY] = (op_sel == TDC_OP_ADD) && add_carry;
            flag_next[TDC_FLAG_BORROW] = (op_sel == TDC_OP_SUB) && sub_borrow;
            flag_next[TDC_FLAG_ZERO] = (op_sel == TDC_OP_ADD) ? add_zero : sub_zero;
        end
        if (err_event) begin
            flag_next[TDC_FLAG_ERR_A] = 1'b1;
            flag_next[TDC_FLAG_ERR_B] = 1'b1;
        end
    end

    // Flag register.
    // Error flags stay set until software clears them.
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            flag_reg <= TDC_FLAG_RST;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // Error code word; the error code overrides a software write in the same cycle.
    // Software may write the word to mark an error as seen.
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            errcode_reg <= TDC_WORD_RST;
        end else if (err_event) begin
            errcode_reg <= TDC_ERR_CODE_RANGE;
        end else if (wr_en && hit_err) begin
            errcode_reg <= wr_word;
        end
    end

    // Outputs straight from flip-flops.
    // The second error flag is seen in the flag word only.
    assign PREADY = pready_reg;
    assign PRDATA = prdata_reg;
    assign PSLVERR = pslverr_reg;
    assign CMP_BITS = cmp_reg;
    assign CARRY_FLAG = flag_reg[TDC_FLAG_CARRY];
    assign ZERO_FLAG = flag_reg[TDC_FLAG_ZERO];
    assign BORROW_FLAG = flag_reg[TDC_FLAG_BORROW];
    assign OP_ERROR = flag_reg[TDC_FLAG_ERR_A];

endmodule : tdc_time_unit

//--- testbench/tdc_time_monitor.sv
`timescale 1ns/1ps
module tdc_time_monitor
    import tdc_pkg::*;
(
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    // Bus pins.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [TDC_ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Results and flags.
    input wire logic [2:0] CMP_BITS,
    input wire logic CARRY_FLAG,
    input wire logic ZERO_FLAG,
    input wire logic BORROW_FLAG,
    input wire logic OP_ERROR
);
    default clocking mon_cb @(posedge REF_CLK);
    endclocking
    default disable iff (SYS_RST);
    // A finished write, and a copy of the enable bit it leaves behind.
    wire wr_done = PSEL && PENABLE && PREADY && PWRITE;
    logic en_reg;
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            en_reg <= 1'b0;
        end else if (wr_done && PADDR == TDC_ADDR_CTRL) begin
            en_reg <= PWDATA[TDC_CTRL_EN_BIT];
        end
    end
    // An access phase is one waiting cycle, then one ready cycle.
    sequence access_s;
        PSEL && PENABLE && !PREADY ##1 PSEL && PENABLE && PREADY;
    endsequence
    ready_timing_a: assert property (PSEL && !PENABLE |=> access_s ##1 !PREADY)
        else $error("ready out of place");
    slverr_ready_a: assert property (PSLVERR |-> PREADY)
        else $error("slave error without ready");
    rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside ready");
    cmp_onehot_a: assert property (CMP_BITS != 3'h0 |-> $onehot(CMP_BITS))
        else $error("several result bits on");
    cmp_hold_a: assert property (!en_reg && !$past(SYS_RST) |=> $stable(CMP_BITS))
        else $error("result bits moved while stopped");
    err_cause_a: assert property (!$past(SYS_RST) && $rose(OP_ERROR)
        |-> $past(en_reg) || $past(wr_done) || $past(wr_done, 2))
        else $error("error flag rose without cause");
    err_sticky_a: assert property (!$past(SYS_RST) && $fell(OP_ERROR)
        |-> $past(wr_done && PADDR == TDC_ADDR_FLAGS && PWDATA[TDC_FLAG_ERR_A]))
        else $error("error flag dropped without clear");
    flags_excl_a: assert property ($onehot0({CARRY_FLAG, ZERO_FLAG, BORROW_FLAG}))
        else $error("arithmetic flags not exclusive");
endmodule : tdc_time_monitor

bind tdc_time_unit tdc_time_monitor tdc_time_monitor_i (.REF_CLK, .SYS_RST, .PSEL,
    .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .CMP_BITS,
    .CARRY_FLAG, .ZERO_FLAG, .BORROW_FLAG, .OP_ERROR);

//--- testbench/tdc_host_model.sv
`timescale 1ns/1ps
module tdc_host_model
    import tdc_pkg::*;
(
    // Clock.
    input wire logic clk,
    // Requests.
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [TDC_ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    // Answers.
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // The bus is idle at time zero.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // One transfer, entered just after an edge; an unanswered one returns an unknown error.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = (pready === 1'b1) ? pslverr : 1'bx;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : xfer
endmodule : tdc_host_model

//--- testbench/time_of_day_compare_arith_test.sv
`timescale 1ns/1ps
module time_of_day_compare_arith_test;
    import tdc_pkg::*;
    // Clock, reset, pins and counters.
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, carry, zero, borrow, op_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0] cmp_bits;
    int bad_count = 0;
    int check_count = 0;
    logic [23:0] cmp_cur [6] = '{24'h0C142C, 24'h0C142D, 24'h0C142E, 24'h073B3B,
        24'h080000, 24'h113B3B};
    logic [23:0] ar_a [7] = '{24'h0A1E28, 24'h173B3B, 24'h140000, 24'h000000,
        24'h0C0000, 24'h0A0000, 24'h010000};
    logic [23:0] ar_b [7] = '{24'h05281E, 24'h000001, 24'h050000, 24'h000000,
        24'h0A1E1E, 24'h0A0000, 24'h020000};
    logic [23:0] ar_r [7] = '{24'h100B0A, 24'h000000, 24'h010000, 24'h000000,
        24'h011D1E, 24'h000000, 24'h170000};
    logic [4:0] ar_f [7] = '{5'h00, 5'h01, 5'h01, 5'h02, 5'h00, 5'h02, 5'h04};
    logic [23:0] er_t [4][3] = '{'{24'h180000, 24'h0, 24'h0}, '{24'h0, 24'h0, 24'h0C3C00},
        '{24'h0, 24'h11003C, 24'h0}, '{24'h0, 24'h003C00, 24'h0}};
    // The clock.
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    tdc_time_unit tdc_time_unit_i (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CMP_BITS(cmp_bits),
        .CARRY_FLAG(carry), .ZERO_FLAG(zero), .BORROW_FLAG(borrow), .OP_ERROR(op_err));
    tdc_host_model tdc_host_model_i (.clk(ref_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    // Counts one comparison of a word.
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk_w
    // Counts one comparison of the flag pins.
    task automatic chk_p(input logic [3:0] exp);
        check_count++;
        if ({op_err, borrow, zero, carry} !== exp) begin
            bad_count++;
            $display("FAIL %0t flag pins differ from %h", $time, exp);
        end
    endtask : chk_p
    // One access with its slave error answer compared.
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic e, output logic [31:0] q);
        logic got_e;
        tdc_host_model_i.xfer(w, a, d, q, got_e);
        chk_w({31'h0, got_e}, {31'h0, e});
    endtask : acc
    // A mapped write, and a mapped read with its value compared.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        acc(1'b1, a, d, 1'b0, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        acc(1'b0, a, 32'h0, 1'b0, q);
        chk_w(q, exp);
    endtask : rd
    // Writes an hour, minute, second triple to three consecutive words.
    task automatic load(input logic [7:0] a, input logic [23:0] t);
        wr(a, {24'h0, t[23:16]});
        wr(a + 8'h04, {24'h0, t[15:8]});
        wr(a + 8'h08, {24'h0, t[7:0]});
    endtask : load
    // Loads the operands, current time last, runs one operation and stops it.
    task automatic run(input logic [2:0] ctl, input logic [23:0] a, input logic [23:0] b,
                       input logic [23:0] c);
        load(TDC_ADDR_OPND_FIRST, a);
        load(TDC_ADDR_OPND_FIRST + 8'h0C, b);
        load(TDC_ADDR_OPND_FIRST + 8'h18, c);
        wr(TDC_ADDR_CTRL, {28'h0, ctl, 1'b1});
        wr(TDC_ADDR_CTRL, 32'h0);
    endtask : run
    // Reads the result triple and the flags, and looks at the flag pins.
    task automatic res(input logic [23:0] t, input logic [4:0] f);
        rd(TDC_ADDR_RES_HOUR, {24'h0, t[23:16]});
        rd(TDC_ADDR_RES_MIN, {24'h0, t[15:8]});
        rd(TDC_ADDR_RES_SEC, {24'h0, t[7:0]});
        rd(TDC_ADDR_FLAGS, {27'h0, f});
        chk_p({f[3], f[2:0]});
    endtask : res
    // Prints the counts and the verdict, then stops.
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        $display("FAIL %0t watchdog expired", $time);
        wrap_up;
    end
    // The tests.
    initial begin
        logic [31:0] q;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        res(24'h0, 5'h00);
        acc(1'b0, 8'h4C, 32'h0, 1'b1, q);
        chk_w(q, 32'h0);
        acc(1'b1, 8'h05, 32'h1, 1'b1, q);
        rd(TDC_ADDR_OPND_FIRST, 32'h0);
        $display("test reset_map done");
        for (int i = 0; i < 6; i++) begin
            run(i < 3 ? {1'b0, TDC_OP_POINT} : {1'b0, TDC_OP_ZONE},
                i < 3 ? 24'h0C142D : 24'h080000, 24'h110000, cmp_cur[i]);
            rd(TDC_ADDR_CMP, {29'h0, 3'h1 << (i % 3)});
            chk_w({29'h0, cmp_bits}, {29'h0, 3'h1 << (i % 3)});
        end
        load(TDC_ADDR_OPND_FIRST + 8'h18, 24'h070000);
        repeat (3) @(posedge ref_clk);
        rd(TDC_ADDR_CMP, 32'h4);
        load(TDC_ADDR_CLK_HOUR, 24'h0C142D);
        run({1'b1, TDC_OP_POINT}, 24'h0C142D, 24'h0, 24'h0);
        rd(TDC_ADDR_CMP, 32'h2);
        $display("test compare done");
        for (int i = 0; i < 7; i++) begin
            run(i < 4 ? {1'b0, TDC_OP_ADD} : {1'b0, TDC_OP_SUB}, ar_a[i], ar_b[i], 24'h0);
            res(ar_r[i], ar_f[i]);
        end
        $display("test arithmetic done");
        for (int i = 0; i < 4; i++) begin
            wr(TDC_ADDR_FLAGS, 32'h1F);
            wr(TDC_ADDR_ERRCODE, 32'h0);
            run({1'b0, 2'(i)}, er_t[i][0], er_t[i][1], er_t[i][2]);
            res(24'h170000, 5'h18);
            rd(TDC_ADDR_ERRCODE, 32'h0E1A);
            rd(TDC_ADDR_CMP, 32'h2);
        end
        wr(TDC_ADDR_FLAGS, 32'h1F);
        chk_p(4'h0);
        wr(TDC_ADDR_ERRCODE, 32'h0);
        rd(TDC_ADDR_ERRCODE, 32'h0);
        wr(TDC_ADDR_CLK_SEC, 32'h3C);
        rd(TDC_ADDR_CLK_SEC, 32'h2D);
        rd(TDC_ADDR_FLAGS, 32'h18);
        rd(TDC_ADDR_ERRCODE, 32'h0E1A);
        wr(TDC_ADDR_CLK_SEC, 32'h3B);
        rd(TDC_ADDR_CLK_SEC, 32'h3B);
        $display("test errors done");
        sys_rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        res(24'h0, 5'h00);
        rd(TDC_ADDR_CMP, 32'h0);
        $display("test second_reset done");
        wrap_up;
    end
endmodule : time_of_day_compare_arith_test
